// [rtl/cdr_regs.sv]
// Result, status and calibration registers of the two-channel capacitance converter
//
// What this block does
// - Status bit 7 reads 1 on low supply or power-down mode, else 0.
// - Status bits 6 to 3 always read zero.
// - Status bit 2 names the channel of the latest stored conversion result, 0 or 1.
// - Status bit 1 drops to 0 when fresh unread second-channel data is held.
// - Status bit 0 drops to 0 when fresh unread first-channel data is held.
// - Each result register is 16 bits over two bytes, read-only, resets to zero.
// - Result sits in upper 12 bits; low 4 bits always read zero.
// - Nominal calibration maps raw 0x3000..0xCFF0 onto result 0x0000..0xFFF0.
// - Codes 0x0000/0x8000/0xFFF0 mean negative/zero/positive full scale, or zero/mid/full.
// - Differential result is (raw minus (offset minus 0x8000)) times gain plus 0x8000.
// - Single-ended result is (raw minus (offset minus 0x3000)) times gain.
// - Gain factor is (2^16 plus gain coefficient) divided by 2^16.
// - Conversion updates its result unless that register is being read until stop.
// - Offset coefficient per channel is 16 bits, read-write, resets to 0x8000.
// - Offset loads from offset calibration at zero input or from a host write.
// - Each channel has independent offset and gain coefficient registers.
// - Gain coefficient is 16 bits read-write, power-on value from factory trim.
// - Setup bit 5 selects differential (1) or single-ended (0) input.
// - Setup bits 7:6 select the input range for the modulator.
// - Setup registers at 0x0B and 0x0E reset to 0x00; low five bits stay zero.
// - Register pointer increments after each byte until the stop condition.
// - Mode 101 runs offset calibration, mode 110 gain calibration, on converting channels.
`timescale 1ns/100ps

module cdr_regs (
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_nrst,
	input  wire logic                 i_low_supply,
	input  wire logic [2:0]           i_conv_mode,
	input  wire logic [1:0][15:0]     i_factory_gain,
	input  wire cdr_pkg::cdr_conv_type i_conv,
	input  wire cdr_pkg::cdr_host_type i_host,
	output logic      [7:0]           o_rd_data,
	output logic      [1:0][2:0]      o_input_setup
);

	// ==========================================================
	// State
	cdr_pkg::cdr_state_type state;
	cdr_pkg::cdr_state_type next_state;

	// ==========================================================
	// Correction datapath for the converting channel
	logic               conv_diff;
	logic [15:0]        conv_zero;
	logic [15:0]        conv_span;
	logic [15:0]        conv_base;
	logic signed [17:0] centred;
	logic signed [17:0] gain_factor;
	logic signed [35:0] product;
	logic signed [20:0] scaled;
	logic signed [20:0] shifted;
	logic [15:0]        corrected;
	logic [15:0]        zero_from_cal;

	// Stored setup field is {range1, range0, differential_select}
	assign conv_diff   = state.setup[i_conv.chan][cdr_pkg::SETUP_DIFF_BIT
		- cdr_pkg::SETUP_FIELD_LSB];
	assign conv_zero   = state.zero_coeff[i_conv.chan];
	assign conv_span   = state.span_coeff[i_conv.chan];
	// Offset reference differs between input modes
	assign conv_base   = conv_diff ? cdr_pkg::MID_DIFF : cdr_pkg::BASE_SE;
	// Raw code less the offset error, in signed form
	assign centred     = $signed({2'b00, i_conv.raw}) - $signed({2'b00, conv_zero})
		+ $signed({2'b00, conv_base});
	assign gain_factor = $signed({1'b0, 1'b1, conv_span});
	assign product     = centred * gain_factor;
	// Upper product bits give the floor of the division, sign kept
	assign scaled      = {product[35], product[35:cdr_pkg::GAIN_SHIFT]};
	// Midscale is added back only in differential mode
	assign shifted     = scaled + (conv_diff ? $signed({5'h00, cdr_pkg::MID_DIFF})
		: $signed(21'h000000));

	// Clamp to the legal code span and clear the unused low bits
	always_comb begin
		if (shifted < $signed(21'h000000)) begin
			corrected = 16'h0000;
		end else if (shifted > $signed({5'h00, cdr_pkg::RESULT_MAX})) begin
			corrected = cdr_pkg::RESULT_MAX;
		end else begin
			corrected = {shifted[15:cdr_pkg::RESULT_LOW_BITS],
				{cdr_pkg::RESULT_LOW_BITS{1'b0}}};
		end
	end

	// Offset coefficient that makes the present input read as zero scale when single-ended; differential stores the raw code
	assign zero_from_cal = conv_diff ? i_conv.raw : 16'(i_conv.raw + cdr_pkg::BASE_SE);

	// ==========================================================
	// Read multiplexer
	function automatic logic [7:0] read_byte(input cdr_pkg::cdr_state_type s);
		logic [7:0] b;
		b = 8'h00;
		if (s.ptr == cdr_pkg::ADDR_STATUS) begin
			b[cdr_pkg::STAT_SLEEP_BIT]     = s.supply_low
				|| (i_conv_mode == cdr_pkg::MODE_POWER_DOWN);
			b[cdr_pkg::STAT_LAST_CHAN_BIT] = s.last_chan;
			b[cdr_pkg::STAT_FRESH2_BIT]    = s.fresh_n[1];
			b[cdr_pkg::STAT_FRESH1_BIT]    = s.fresh_n[0];
		end
		for (int c = 0; c < 2; c++) begin
			if (s.ptr == cdr_pkg::ADDR_RESULT_HI[c]) begin
				b = s.result[c][15:8];
			end
			if (s.ptr == cdr_pkg::ADDR_RESULT_LO[c]) begin
				b = s.result[c][7:0];
			end
			if (s.ptr == cdr_pkg::ADDR_ZERO_HI[c]) begin
				b = s.zero_coeff[c][15:8];
			end
			if (s.ptr == cdr_pkg::ADDR_ZERO_LO[c]) begin
				b = s.zero_coeff[c][7:0];
			end
			if (s.ptr == cdr_pkg::ADDR_SPAN_HI[c]) begin
				b = s.span_coeff[c][15:8];
			end
			if (s.ptr == cdr_pkg::ADDR_SPAN_LO[c]) begin
				b = s.span_coeff[c][7:0];
			end
			if (s.ptr == cdr_pkg::ADDR_SETUP[c]) begin
				// Unused low bits read as zero
				b = {s.setup[c], {cdr_pkg::SETUP_FIELD_LSB{1'b0}}};
			end
		end
		return b;
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		logic [1:0] reading;
		logic [1:0] accept;
		reading    = 2'b00;
		accept     = 2'b00;
		next_state = state;

		// Supply monitor crosses in through two flops
		next_state.supply_meta = i_low_supply;
		next_state.supply_low  = state.supply_meta;

		// Factory trim is taken once, the first edge after reset release
		if (!state.span_loaded) begin
			next_state.span_coeff  = i_factory_gain;
			next_state.span_loaded = 1'b1;
		end

		// Pointer handling: load, then step after every byte
		if (i_host.ptr_load) begin
			next_state.ptr = i_host.data;
		end else if (i_host.wr_valid || i_host.rd_ack) begin
			next_state.ptr = 8'(state.ptr + 8'h01);
		end

		for (int c = 0; c < 2; c++) begin
			// A byte of this result taken now also counts as a read in progress
			reading[c] = state.rd_lock[c] || (i_host.rd_ack
				&& (state.ptr == cdr_pkg::ADDR_RESULT_HI[c]
				|| state.ptr == cdr_pkg::ADDR_RESULT_LO[c]));

			accept[c] = i_conv.done && (i_conv.chan == c[0]) && !reading[c];

			// Normal conversion, offset and gain calibration
			if (accept[c]) begin
				if (i_conv_mode == cdr_pkg::MODE_OFFSET_CAL) begin
					next_state.zero_coeff[c] = zero_from_cal;
				end else if (i_conv_mode == cdr_pkg::MODE_GAIN_CAL) begin
					// Gain engine delivers the new coefficient on the raw code
					next_state.span_coeff[c] = i_conv.raw;
				end else begin
					next_state.result[c]  = corrected;
					next_state.fresh_n[c] = 1'b0;
					next_state.last_chan  = c[0];
				end
			end

			// Read ends at stop: release the lock and mark the data as read
			if (i_host.stop) begin
				next_state.rd_lock[c] = 1'b0;
				if (reading[c]) begin
					next_state.fresh_n[c] = 1'b1;
				end
			end else begin
				next_state.rd_lock[c] = reading[c];
			end

			// Host writes win over a calibration landing in the same cycle
			if (i_host.wr_valid && !i_host.ptr_load) begin
				if (state.ptr == cdr_pkg::ADDR_ZERO_HI[c]) begin
					next_state.zero_coeff[c][15:8] = i_host.data;
				end
				if (state.ptr == cdr_pkg::ADDR_ZERO_LO[c]) begin
					next_state.zero_coeff[c][7:0] = i_host.data;
				end
				if (state.ptr == cdr_pkg::ADDR_SPAN_HI[c]) begin
					next_state.span_coeff[c][15:8] = i_host.data;
				end
				if (state.ptr == cdr_pkg::ADDR_SPAN_LO[c]) begin
					next_state.span_coeff[c][7:0] = i_host.data;
				end
				if (state.ptr == cdr_pkg::ADDR_SETUP[c]) begin
					next_state.setup[c] = i_host.data[7:cdr_pkg::SETUP_FIELD_LSB];
				end
			end
		end

		// Range and mode fields as handed to the modulator
		next_state.setup_out = next_state.setup;
		next_state.rd_data   = read_byte(state);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state.ptr         <= 8'h00;
			state.rd_lock     <= 2'b00;
			state.result      <= {2{cdr_pkg::RESULT_RST}};
			state.zero_coeff  <= {2{cdr_pkg::ZERO_RST}};
			state.span_coeff  <= {2{cdr_pkg::SPAN_RST}};
			state.setup       <= {2{cdr_pkg::SETUP_RST}};
			state.fresh_n     <= {2{cdr_pkg::FRESH_N_RST}};
			state.last_chan   <= 1'b0;
			state.supply_meta <= 1'b0;
			state.supply_low  <= 1'b0;
			state.span_loaded <= 1'b0;
			state.rd_data     <= 8'h00;
			state.setup_out   <= {2{cdr_pkg::SETUP_RST}};
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// Outputs
	assign o_rd_data     = state.rd_data;
	assign o_input_setup = state.setup_out;

endmodule

// [rtl/cdr_pkg.sv]
// Shared constants and carrier types of the converter result and calibration registers
package cdr_pkg;

	// ==========================================================
	// Register addresses, index 0 is the first channel
	localparam logic [7:0]       ADDR_STATUS    = 8'h00;
	localparam logic [1:0][7:0]  ADDR_RESULT_HI = {8'h03, 8'h01};
	localparam logic [1:0][7:0]  ADDR_RESULT_LO = {8'h04, 8'h02};
	localparam logic [1:0][7:0]  ADDR_ZERO_HI   = {8'h07, 8'h05};
	localparam logic [1:0][7:0]  ADDR_ZERO_LO   = {8'h08, 8'h06};
	localparam logic [1:0][7:0]  ADDR_SPAN_HI   = {8'h0c, 8'h09};
	localparam logic [1:0][7:0]  ADDR_SPAN_LO   = {8'h0d, 8'h0a};
	localparam logic [1:0][7:0]  ADDR_SETUP     = {8'h0e, 8'h0b};

	// ==========================================================
	// Field positions
	localparam int               STAT_SLEEP_BIT     = 7;
	localparam int               STAT_LAST_CHAN_BIT = 2;
	localparam int               STAT_FRESH2_BIT    = 1;
	localparam int               STAT_FRESH1_BIT    = 0;
	localparam int               SETUP_DIFF_BIT     = 5;
	localparam int               SETUP_FIELD_LSB    = 5;
	localparam int               RESULT_LOW_BITS    = 4;
	localparam int               GAIN_SHIFT         = 16;

	// ==========================================================
	// Reset values and code constants
	localparam logic [15:0]      RESULT_RST  = 16'h0000;
	localparam logic [15:0]      ZERO_RST    = 16'h8000;
	localparam logic [15:0]      SPAN_RST    = 16'h0000;
	localparam logic [2:0]       SETUP_RST   = 3'h0;
	localparam logic             FRESH_N_RST = 1'b1;
	localparam logic [15:0]      MID_DIFF    = 16'h8000;
	localparam logic [15:0]      BASE_SE     = 16'h3000;
	localparam logic [15:0]      RESULT_MAX  = 16'hfff0;

	// ==========================================================
	// Converter mode codes as driven by the configuration register
	localparam logic [2:0]       MODE_POWER_DOWN = 3'h3;
	localparam logic [2:0]       MODE_OFFSET_CAL = 3'h5;
	localparam logic [2:0]       MODE_GAIN_CAL   = 3'h6;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        done;
		logic        chan;
		logic [15:0] raw;
	} cdr_conv_type;

	typedef struct packed {
		logic        ptr_load;
		logic        wr_valid;
		logic        rd_ack;
		logic        stop;
		logic [7:0]  data;
	} cdr_host_type;

	typedef struct packed {
		logic [7:0]       ptr;
		logic [1:0]       rd_lock;
		logic [1:0][15:0] result;
		logic [1:0][15:0] zero_coeff;
		logic [1:0][15:0] span_coeff;
		logic [1:0][2:0]  setup;
		logic [1:0]       fresh_n;
		logic             last_chan;
		logic             supply_meta;
		logic             supply_low;
		logic             span_loaded;
		logic [7:0]       rd_data;
		logic [1:0][2:0]  setup_out;
	} cdr_state_type;

endpackage

// [sim/cdr_regs_properties.sv]
// Assertion checker for the converter register block
`timescale 1ns/100ps
module cdr_regs_properties (
	input wire logic                  i_ref_clk,
	input wire logic                  i_nrst,
	input wire logic                  i_low_supply,
	input wire logic [2:0]            i_conv_mode,
	input wire logic [1:0][15:0]      i_factory_gain,
	input wire cdr_pkg::cdr_conv_type i_conv,
	input wire cdr_pkg::cdr_host_type i_host,
	input wire logic [7:0]            o_rd_data,
	input wire logic [1:0][2:0]       o_input_setup
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	// ==========================================================
	// Pointer mirror; p1 starts unmapped so the first edge stays quiet
	logic [7:0] ptr;
	logic [7:0] p1;
	logic [1:0] lk;
	wire        idle = !(i_host.ptr_load || i_host.wr_valid || i_host.rd_ack || i_host.stop);
	wire        acc = i_conv.done && idle && ptr == 8'h00 && !lk[i_conv.chan]
		&& i_conv_mode != cdr_pkg::MODE_OFFSET_CAL && i_conv_mode != cdr_pkg::MODE_GAIN_CAL;
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ptr <= 8'h00;
			p1 <= 8'hff;
			lk <= 2'h0;
		end else begin
			p1 <= ptr;
			if (i_host.ptr_load) begin
				ptr <= i_host.data;
			end else if (i_host.wr_valid || i_host.rd_ack) begin
				ptr <= ptr + 8'h01;
			end
			if (i_host.stop) begin
				lk <= 2'h0;
			end else if (i_host.rd_ack && ptr >= 8'h01 && ptr <= 8'h04) begin
				lk[ptr > 8'h02] <= 1'b1;
			end
		end
	end
	// ==========================================================
	// Properties
	sequence s_setup_wr(int ch);
		i_host.wr_valid && !i_host.ptr_load && ptr == cdr_pkg::ADDR_SETUP[ch];
	endsequence
	a_status_unused_zero: assert property (p1 == 8'h00 |-> o_rd_data[6:3] == 4'h0)
		else $error("status unused bits not zero");
	a_result_low_zero: assert property ((p1 == 8'h02 || p1 == 8'h04) |-> o_rd_data[3:0] == 4'h0)
		else $error("result low nibble not zero");
	a_setup_low_zero: assert property ((p1 == 8'h0b || p1 == 8'h0e) |-> o_rd_data[4:0] == 5'h00)
		else $error("setup low bits not zero");
	a_unmapped_reads_zero: assert property (p1 > 8'h0f |-> o_rd_data == 8'h00)
		else $error("unmapped address read nonzero");
	a_sleep_mode_flag: assert property (p1 == 8'h00 && $past(i_conv_mode) == 3'h3 |-> o_rd_data[7])
		else $error("power-down not flagged in status");
	a_setup_ch1_out: assert property (s_setup_wr(0) |-> ##2 o_input_setup[0] == $past(i_host.data[7:5], 2))
		else $error("first channel setup output wrong");
	a_setup_ch2_out: assert property (s_setup_wr(1) |-> ##2 o_input_setup[1] == $past(i_host.data[7:5], 2))
		else $error("second channel setup output wrong");
	a_fresh_flag_drop: assert property (acc |-> ##2 !o_rd_data[$past(i_conv.chan, 2)])
		else $error("ready flag did not drop after conversion");
endmodule

bind cdr_regs cdr_regs_properties u_props (.i_ref_clk, .i_nrst, .i_low_supply, .i_conv_mode,
	.i_factory_gain, .i_conv, .i_host, .o_rd_data, .o_input_setup);

// [sim/cdr_host_model.sv]
// Host controller model for the byte register port
`timescale 1ns/100ps
module cdr_host_model (
	input  wire logic             i_ref_clk,
	input  wire logic [7:0]       i_rd_data,
	output cdr_pkg::cdr_host_type o_host
);
	initial o_host = '0;
	// One event, taken at the second edge; released data shows a new pattern
	task automatic xfer(input logic [3:0] k, input logic [7:0] v, output logic [7:0] d);
		@(posedge i_ref_clk);
		o_host <= {k, v};
		@(posedge i_ref_clk);
		d = i_rd_data;
		o_host <= {4'h0, ~v};
	endtask
	task automatic point(input logic [7:0] a);
		logic [7:0] d;
		xfer(4'h8, a, d);
	endtask
	task automatic wr(input logic [7:0] v);
		logic [7:0] d;
		xfer(4'h4, v, d);
	endtask
	task automatic rd(output logic [7:0] d);
		xfer(4'h2, 8'h00, d);
	endtask
	task automatic stp;
		logic [7:0] d;
		xfer(4'h1, 8'h00, d);
	endtask
	// Both bytes in one transfer keep the pair consistent
	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		point(a);
		rd(v[15:8]);
		rd(v[7:0]);
		stp();
	endtask
endmodule

// [sim/test_cdc_result_calibration_regs.sv]
// Self-checking bench for the converter register block
`timescale 1ns/100ps
module test_cdc_result_calibration_regs;
	logic                  i_ref_clk;
	logic                  i_nrst;
	logic                  i_low_supply;
	logic [2:0]            i_conv_mode;
	logic [1:0][15:0]      i_factory_gain;
	cdr_pkg::cdr_conv_type i_conv;
	cdr_pkg::cdr_host_type i_host;
	logic [7:0]            o_rd_data;
	logic [1:0][2:0]       o_input_setup;
	logic [15:0]           off [2];
	logic [15:0]           gn [2];
	logic [15:0]           res [2];
	logic [7:0]            su [2];
	logic                  last;
	logic                  pd;
	logic [7:0]            b;
	logic [15:0]           w;
	logic [7:0]            wb [14] = '{8'haa, 8'haa, 8'haa, 8'haa, 8'hb8, 8'h00, 8'h30, 8'h00,
		8'h10, 8'h00, 8'he0, 8'h00, 8'h00, 8'h80};
	logic [16:0]           cv [5] = '{{1'b0, 16'h4005}, {1'b0, 16'h3800}, {1'b0, 16'hffff},
		{1'b1, 16'hcff7}, {1'b1, 16'h0005}};
	int                    n_mismatch = 0;
	int                    n_tests = 0;

	cdr_regs DUT (.i_ref_clk, .i_nrst, .i_low_supply, .i_conv_mode, .i_factory_gain, .i_conv,
		.i_host, .o_rd_data, .o_input_setup);
	cdr_host_model host (.i_ref_clk, .i_rd_data(o_rd_data), .o_host(i_host));

	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	// ==========================================================
	// Helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] calc(input logic d, input logic [15:0] o, g, r);
		longint c;
		c = longint'(r) - longint'(o) + (d ? 64'sh8000 : 64'sh3000);
		c = (c * (64'sh10000 + longint'(g))) >>> cdr_pkg::GAIN_SHIFT;
		c = d ? c + 64'sh8000 : c;
		c = c < 0 ? 64'sh0 : (c > 64'shfff0 ? 64'shfff0 : c);
		return c[15:0] & 16'hfff0;
	endfunction
	task automatic conv(input logic ch, input logic [15:0] r);
		@(posedge i_ref_clk);
		i_conv <= {1'b1, ch, r};
		@(posedge i_ref_clk);
		i_conv <= {1'b0, ch, ~r};
	endtask
	task automatic rs(output logic [7:0] v);
		host.point(8'h00);
		host.rd(v);
		host.stp();
	endtask
	task automatic map_chk;
		logic [7:0] e [15];
		logic [7:0] v;
		e = '{{pd, 4'h0, last, 2'h3}, res[0][15:8], res[0][7:0], res[1][15:8], res[1][7:0],
			off[0][15:8], off[0][7:0], off[1][15:8], off[1][7:0], gn[0][15:8], gn[0][7:0],
			su[0], gn[1][15:8], gn[1][7:0], su[1]};
		host.point(8'h00);
		for (int a = 0; a < 15; a++) begin
			host.rd(v);
			chk(16'(v), 16'(e[a]));
		end
		host.stp();
		host.point(8'h20);
		host.rd(v);
		host.stp();
		chk(16'(v), 16'h0000);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Tests run well under two thousand cycles
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		i_nrst = 1'b0;
		i_low_supply = 1'b0;
		i_conv_mode = 3'h1;
		i_factory_gain = {16'h0010, 16'h1000};
		i_conv = '0;
		off = '{16'h8000, 16'h8000};
		gn = '{16'h1000, 16'h0010};
		res = '{16'h0000, 16'h0000};
		su = '{8'h00, 8'h00};
		last = 1'b0;
		pd = 1'b0;
		repeat (8) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		map_chk();
		host.point(8'h01);
		foreach (wb[i]) host.wr(wb[i]);
		host.stp();
		off = '{16'hb800, 16'h3000};
		gn = '{16'h1000, 16'h0000};
		su = '{8'he0, 8'h80};
		chk({10'h000, o_input_setup}, 16'h0027);
		map_chk();
		foreach (cv[i]) begin
			host.point(8'h00);
			conv(cv[i][16], cv[i][15:0]);
			last = cv[i][16];
			res[last] = calc(su[last][5], off[last], gn[last], cv[i][15:0]);
			rs(b);
			chk(16'(b), {13'h0000, last, ~last, last});
			host.rd16(last ? 8'h03 : 8'h01, w);
			chk(w, res[last]);
			rs(b);
			chk(16'(b), {13'h0000, last, 2'h3});
		end
		host.point(8'h01);
		host.rd(b);
		conv(1'b0, 16'h5000);
		host.rd(b);
		host.stp();
		chk(16'(b), 16'(res[0][7:0]));
		i_conv_mode <= cdr_pkg::MODE_OFFSET_CAL;
		conv(1'b0, 16'h4321);
		conv(1'b1, 16'h0100);
		i_conv_mode <= cdr_pkg::MODE_GAIN_CAL;
		conv(1'b1, 16'h0abc);
		i_conv_mode <= cdr_pkg::MODE_POWER_DOWN;
		off = '{16'h4321, 16'h3100};
		gn[1] = 16'h0abc;
		pd = 1'b1;
		map_chk();
		i_conv_mode <= 3'h1;
		i_low_supply <= 1'b1;
		rs(b);
		chk(16'(b), {8'h00, 1'b1, 4'h0, last, 2'h3});
		i_low_supply <= 1'b0;
		rs(b);
		chk(16'(b), {13'h0000, last, 2'h3});
		// ==========================================================
		// Reset in mid-run with a new factory trim on the pins
		@(posedge i_ref_clk);
		i_factory_gain <= {16'h0055, 16'hc001};
		i_nrst <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		off = '{16'h8000, 16'h8000};
		gn = '{16'hc001, 16'h0055};
		res = '{16'h0000, 16'h0000};
		su = '{8'h00, 8'h00};
		last = 1'b0;
		pd = 1'b0;
		chk({10'h000, o_input_setup}, 16'h0000);
		map_chk();
		report_and_stop();
	end
endmodule
